//--- health_pkg.sv
package health_pkg;

  // register map, word addresses as seen by the supervisory master
  localparam logic [7:0]  FAULT_WORD_ADDR    = 8'h07;
  localparam logic [7:0]  INDICATOR_ADDR     = 8'h09;
  localparam logic [15:0] REG_RESET_VALUE    = 16'h0000;

  // fault word bit positions
  localparam int FAULT_POS_BIT   = 0;
  localparam int FAULT_CHG_BIT   = 1;
  localparam int FAULT_MOTOR_BIT = 2;
  localparam int FAULT_RANGE_BIT = 3;
  localparam int FAULT_BITS      = 4;

  // indicator codes
  localparam logic [15:0] CODE_HEALTHY   = 16'h0000;
  localparam logic [15:0] CODE_RED1      = 16'h0001;
  localparam logic [15:0] CODE_RED2      = 16'h0002;
  localparam logic [15:0] CODE_RED3      = 16'h0003;
  localparam logic [15:0] CODE_RED4      = 16'h0004;
  localparam logic [15:0] CODE_RED5      = 16'h0005;
  localparam logic [15:0] CODE_YEL1      = 16'h0010;
  localparam logic [15:0] CODE_YEL2      = 16'h0020;
  localparam logic [15:0] CODE_YEL3      = 16'h0030;
  localparam logic [15:0] CODE_YEL4      = 16'h0040;
  localparam logic [15:0] CODE_YEL5      = 16'h0050;
  localparam logic [15:0] CODE_ACQUIRING = 16'h0100;

  // thresholds in measurement units: tenths of volts, milliamps, degrees F
  localparam logic [15:0] BAT_LOW_LIMIT   = 16'h0072; // 11.4 V
  localparam logic [15:0] BAT_HIGH_LIMIT  = 16'h00AF; // 17.5 V
  localparam logic [15:0] BAT_WARN_LIMIT  = 16'h0079; // 12.1 V
  localparam logic [15:0] JAM_CURRENT     = 16'h1194; // 4500 mA
  localparam logic [15:0] WARN_CURRENT    = 16'h0DAC; // 3500 mA
  localparam logic [15:0] S36_LOW_LIMIT   = 16'h014A; // 33.0 V
  localparam logic [15:0] S36_HIGH_LIMIT  = 16'h0186; // 39.0 V
  localparam logic [15:0] S5_LOW_LIMIT    = 16'h002D; // 4.5 V
  localparam logic [15:0] S5_HIGH_LIMIT   = 16'h0037; // 5.5 V
  localparam logic signed [15:0] TEMP_LOW_LIMIT  = 16'sh0000; // 0 F
  localparam logic signed [15:0] TEMP_HIGH_LIMIT = 16'sh00B0; // 176 F

  // live measurements from the subsystem modules
  typedef struct packed {
    logic [15:0]        bat_volt;   // tenths of a volt
    logic [15:0]        motor_ma;   // milliamps
    logic [15:0]        s36_volt;   // tenths of a volt
    logic [15:0]        s5_volt;    // tenths of a volt
    logic signed [15:0] temp_f;     // degrees F, signed
  } meas_t;

  // link and mode flags
  typedef struct packed {
    logic pos_comm_fail;    // position receiver silent
    logic chg_comm_fail;    // charge controller silent
    logic motor_comm_fail;  // motor controller silent
    logic motor_error;      // motor controller reported error
    logic aux_out_off;      // charger auxiliary output off
    logic acquiring_fix;    // receiver still acquiring satellites
  } link_t;

  // one bit per indicator level, index 0 is level 1
  typedef logic [9:0] level_vec_t;

endpackage

//--- meas_hold.sv
// keeps the last measurement set a module delivered while its link is up
module meas_hold
  import health_pkg::*;
(
  input  wire logic                clk_in,
  input  wire logic                rst_in,
  input  wire health_pkg::meas_t   meas_in,
  input  wire logic                bat_link_ok_in,
  input  wire logic                motor_link_ok_in,
  output health_pkg::meas_t        held_out
);

  ////////////////////////////////////////////////////////////////////////////
  // one process owns the whole struct so no field has two drivers;
  // battery and supply readings come via the charge controller,
  // motor current via the motor controller
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      held_out.bat_volt <= BAT_WARN_LIMIT; // safe value at the warn limit, no false alarm
      held_out.s36_volt <= S36_LOW_LIMIT + 16'h001E;
      held_out.s5_volt  <= S5_LOW_LIMIT + 16'h0005;
      held_out.temp_f   <= 16'sh0046;
      held_out.motor_ma <= 16'h0000;
    end else begin
      if (bat_link_ok_in) begin // stale data stays when link lost
        held_out.bat_volt <= meas_in.bat_volt;
        held_out.s36_volt <= meas_in.s36_volt;
        held_out.s5_volt  <= meas_in.s5_volt;
        held_out.temp_f   <= meas_in.temp_f;
      end
      if (motor_link_ok_in) begin // last current kept on loss
        held_out.motor_ma <= meas_in.motor_ma;
      end
    end
  end

endmodule

//--- level_select.sv
// picks the most urgent active level and maps it to its indicator code
module level_select
  import health_pkg::*;
(
  input  wire logic                    clk_in,
  input  wire logic                    rst_in,
  input  wire health_pkg::level_vec_t  active_in,
  input  wire logic                    acquiring_in,
  output logic [15:0]                  code_out
);

  // code for each level, level 1 first
  localparam logic [15:0] LEVEL_CODE [10] = '{
    CODE_RED5, CODE_RED1, CODE_RED2, CODE_RED3, CODE_RED4,
    CODE_YEL1, CODE_YEL2, CODE_YEL3, CODE_YEL4, CODE_YEL5};

  logic [15:0] code_nxt; // chosen code

  ////////////////////////////////////////////////////////////////////////////
  // scan from least urgent so the lowest active level wins last
  always_comb begin
    code_nxt = acquiring_in ? CODE_ACQUIRING : CODE_HEALTHY;
    for (int i = 9; i >= 0; i--) begin
      if (active_in[i]) begin
        code_nxt = LEVEL_CODE[i]; // lowest number has priority
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered each cycle, follows condition with no latching
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      code_out <= REG_RESET_VALUE;
    end else begin
      code_out <= code_nxt;
    end
  end

endmodule

//--- health_status_reporter.sv
module health_status_reporter
  import health_pkg::*;
#(
  parameter int ADDR_W = 8  // register address width
)
(
  input  wire logic                clk_in,
  input  wire logic                rst_in,
  input  wire health_pkg::meas_t   meas_in,
  input  wire health_pkg::link_t   link_in,
  input  wire logic                rd_en_in,
  input  wire logic [ADDR_W-1:0]   rd_addr_in,
  output logic [15:0]              rd_data_out,
  output logic                     rd_valid_out,
  output logic [15:0]              fault_word_out,
  output logic [15:0]              indicator_out
);

  // the decode compares against 8-bit offsets
  if (ADDR_W < 4) begin : g_addr_check
    $error("ADDR_W too small to reach the status registers");
  end

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  meas_t       held;           // measurements, last known on link loss
  level_vec_t  level_active;   // one bit per indicator level
  logic        bat_oor;        // battery outside hard limits
  logic        s36_oor;        // 36V supply outside limits
  logic        s5_oor;         // 5V supply outside limits
  logic        temp_oor;       // temperature outside limits
  logic        jam_mode;       // jam recovery active
  logic        analog_oor;     // any analog out of range
  logic [15:0] fault_word_nxt; // next status word
  logic [15:0] code;           // selected indicator code
  logic [15:0] rd_data_nxt;    // read mux output
  logic [7:0]  addr8;          // address widened or trimmed to 8 bits

  ////////////////////////////////////////////////////////////////////////////
  // hold stage for the subsystem readings
  meas_hold u_hold (
    .clk_in           (clk_in),
    .rst_in           (rst_in),
    .meas_in          (meas_in),
    .bat_link_ok_in   (!link_in.chg_comm_fail),
    .motor_link_ok_in (!link_in.motor_comm_fail),
    .held_out         (held)
  );

  ////////////////////////////////////////////////////////////////////////////
  // threshold comparisons, all strict
  always_comb begin
    bat_oor  = (held.bat_volt < BAT_LOW_LIMIT) ||
               (held.bat_volt > BAT_HIGH_LIMIT);
    s36_oor  = (held.s36_volt < S36_LOW_LIMIT) ||
               (held.s36_volt > S36_HIGH_LIMIT);
    // upper check is greater-than; a less-than here would always fire
    s5_oor   = (held.s5_volt < S5_LOW_LIMIT) ||
               (held.s5_volt > S5_HIGH_LIMIT);
    temp_oor = (held.temp_f < TEMP_LOW_LIMIT) ||
               (held.temp_f > TEMP_HIGH_LIMIT);
    // jam recovery on overcurrent or a motor controller error
    jam_mode = (held.motor_ma > JAM_CURRENT) || link_in.motor_error;
    analog_oor = bat_oor || s36_oor || s5_oor || temp_oor;
  end

  ////////////////////////////////////////////////////////////////////////////
  // level activity vector, index i is level i+1
  always_comb begin
    level_active[0] = bat_oor;
    level_active[1] = jam_mode;
    level_active[2] = s36_oor && !link_in.aux_out_off;
    level_active[3] = link_in.motor_comm_fail && !link_in.aux_out_off;
    level_active[4] = link_in.chg_comm_fail;
    level_active[5] = held.motor_ma > WARN_CURRENT;
    level_active[6] = held.bat_volt < BAT_WARN_LIMIT;
    level_active[7] = temp_oor;
    level_active[8] = s5_oor;
    level_active[9] = link_in.pos_comm_fail;
  end

  ////////////////////////////////////////////////////////////////////////////
  // priority pick and code mapping
  level_select u_sel (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .active_in    (level_active),
    .acquiring_in (link_in.acquiring_fix),
    .code_out     (code)
  );

  ////////////////////////////////////////////////////////////////////////////
  // status word: each bit its own cause, upper bits zero
  always_comb begin
    fault_word_nxt = 16'h0000;
    fault_word_nxt[FAULT_POS_BIT]   = link_in.pos_comm_fail;
    fault_word_nxt[FAULT_CHG_BIT]   = link_in.chg_comm_fail;
    fault_word_nxt[FAULT_MOTOR_BIT] = link_in.motor_comm_fail;
    fault_word_nxt[FAULT_RANGE_BIT] = analog_oor;
  end

  // status word register, rebuilt every cycle so faults self clear
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fault_word_out <= REG_RESET_VALUE;
    end else begin
      fault_word_out <= fault_word_nxt; // zero when no link has failed and every analog is in range
    end
  end

  // indicator output stage, one more flop so the port is registered
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      indicator_out <= REG_RESET_VALUE;
    end else begin
      indicator_out <= code;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read decode; unmapped addresses read zero
  always_comb begin
    addr8 = 8'h00;
    addr8[((ADDR_W < 8) ? ADDR_W : 8)-1:0] =
      rd_addr_in[((ADDR_W < 8) ? ADDR_W : 8)-1:0];
    if (ADDR_W > 8 && (rd_addr_in >> 8) != '0) begin
      rd_data_nxt = 16'h0000; // beyond the map
    end else if (addr8 == FAULT_WORD_ADDR) begin
      rd_data_nxt = fault_word_out;
    end else if (addr8 == INDICATOR_ADDR) begin
      rd_data_nxt = indicator_out;
    end else begin
      rd_data_nxt = 16'h0000;
    end
  end

  // read answer one cycle after the request; reads have no side effects
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_data_out  <= 16'h0000;
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= rd_en_in;
      if (rd_en_in) begin
        rd_data_out <= rd_data_nxt;
      end
    end
  end

endmodule

//--- health_monitor.sv
module health_monitor
  import health_pkg::*;
#(
  parameter int ADDR_W = 8  // address width, same as the design
)
(
  input  wire logic                clk_in,
  input  wire logic                rst_in,
  input  wire health_pkg::meas_t   meas_in,
  input  wire health_pkg::link_t   link_in,
  input  wire logic                rd_en_in,
  input  wire logic [ADDR_W-1:0]   rd_addr_in,
  input  wire logic [15:0]         rd_data_out,
  input  wire logic                rd_valid_out,
  input  wire logic [15:0]         fault_word_out,
  input  wire logic [15:0]         indicator_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking mon_cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // a read taken at a given word address
  sequence read_req(a);
    rd_en_in && (rd_addr_in == a);
  endsequence
  // link flags reach the code two edges late, so both edges must be out of reset
  sequence settled;
    !$past(rst_in) && !$past(rst_in, 2);
  endsequence
  a_valid_after_read: assert property (rd_en_in |=> rd_valid_out)
    else $error("read not answered one cycle later");
  a_valid_only_read: assert property (!rd_en_in |=> !rd_valid_out)
    else $error("answer without a read");
  a_fault_read_data: assert property (read_req(FAULT_WORD_ADDR) |=>
    rd_data_out == $past(fault_word_out)) else $error("fault word read mismatch");
  a_code_read_data: assert property (read_req(INDICATOR_ADDR) |=>
    rd_data_out == $past(indicator_out)) else $error("indicator read mismatch");
  a_fault_top_zero: assert property (fault_word_out[15:4] == 12'h000)
    else $error("unused fault bits set");
  a_pos_bit_link: assert property (!$past(rst_in) |-> fault_word_out[FAULT_POS_BIT] ==
    $past(link_in.pos_comm_fail)) else $error("receiver fault bit wrong");
  a_chg_bit_link: assert property (!$past(rst_in) |-> fault_word_out[FAULT_CHG_BIT] ==
    $past(link_in.chg_comm_fail)) else $error("charger fault bit wrong");
  a_motor_bit_link: assert property (!$past(rst_in) |-> fault_word_out[FAULT_MOTOR_BIT] ==
    $past(link_in.motor_comm_fail)) else $error("motor fault bit wrong");
  a_chg_shows_red: assert property (settled and $past(link_in.chg_comm_fail, 2) |->
    indicator_out inside {CODE_RED1, CODE_RED2, CODE_RED3, CODE_RED4, CODE_RED5})
    else $error("charger link fault not shown red");
  a_jam_shows_red: assert property (settled and $past(link_in.motor_error, 2) |->
    indicator_out inside {CODE_RED1, CODE_RED5}) else $error("jam recovery not shown");
endmodule

bind health_status_reporter health_monitor #(.ADDR_W(ADDR_W)) health_monitor_inst (
  .clk_in(clk_in), .rst_in(rst_in), .meas_in(meas_in), .link_in(link_in),
  .rd_en_in(rd_en_in), .rd_addr_in(rd_addr_in), .rd_data_out(rd_data_out),
  .rd_valid_out(rd_valid_out), .fault_word_out(fault_word_out), .indicator_out(indicator_out));

//--- scada_poller.sv
// supervisory master: one read strobe a poll, answer awaited under a bound
module scada_poller
(
  input  wire logic        clk_in,
  input  wire logic        rd_valid_in,
  input  wire logic [15:0] rd_data_in,
  output logic             rd_en_out,
  output logic [7:0]       rd_addr_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    rd_en_out   = 1'b0;
    rd_addr_out = 8'h00;
  end
  // strobe lasts one cycle as the bus allows; ok stays low if no answer arrives
  task automatic read_word(input logic [7:0] addr, output logic [15:0] data, output logic ok);
    ok   = 1'b0;
    data = 16'h0000;
    @(posedge clk_in);
    rd_en_out   <= 1'b1;
    rd_addr_out <= addr;
    @(posedge clk_in);
    rd_en_out   <= 1'b0;
    rd_addr_out <= ~addr;  // released address must not look still valid
    for (int i = 0; i < 4 && !ok; i++) begin
      #1;
      if (rd_valid_in === 1'b1) begin
        data = rd_data_in;
        ok   = 1'b1;
      end else begin
        @(posedge clk_in);
      end
    end
  endtask
endmodule

//--- test_health_status_reporter.sv
module test_health_status_reporter import health_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, rst_in, rd_en_in, rd_valid_out;
  logic [7:0]  rd_addr_in;
  logic [15:0] rd_data_out, fault_word_out, indicator_out;
  meas_t       meas_in;
  link_t       link_in;
  int          bad_count, compares;
  // benign set: 13.0 V, 1000 mA, 36.0 V, 5.0 V, 70 F; index 4 bat .. 0 temp
  localparam logic [4:0][15:0] BASE = {16'h0082, 16'h03E8, 16'h0168, 16'h0032, 16'h0046};
  health_status_reporter health_status_reporter_inst (.clk_in(clk_in), .rst_in(rst_in),
    .meas_in(meas_in), .link_in(link_in), .rd_en_in(rd_en_in), .rd_addr_in(rd_addr_in),
    .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .fault_word_out(fault_word_out),
    .indicator_out(indicator_out));
  scada_poller scada_poller_inst (.clk_in(clk_in), .rd_valid_in(rd_valid_out),
    .rd_data_in(rd_data_out), .rd_en_out(rd_en_in), .rd_addr_out(rd_addr_in));
  always #2.5 clk_in = ~clk_in;
  // verdict and end of run, reached from the main sequence or a lost answer
  task automatic complete_run();
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // register read through the poller; a missing answer ends the run
  task automatic rd(input logic [7:0] addr, input logic [15:0] exp, input string what);
    logic [15:0] d;
    logic        ok;
    scada_poller_inst.read_word(addr, d, ok);
    if (!ok) begin
      bad_count++;
      complete_run();
    end
    check(d, exp, what);
  endtask
  // replace one measurement, set the flags, let the pipeline settle, check both views
  task automatic go(input int idx, input logic [15:0] val, input logic [5:0] lnk,
                    input logic [3:0] ef, input logic [15:0] ec);
    logic [4:0][15:0] f;
    f      = BASE;
    f[idx] = val;
    @(posedge clk_in);
    meas_in <= f;
    link_in <= lnk;
    repeat (4) @(posedge clk_in);
    #1;
    check(fault_word_out, {12'h000, ef}, "fault word");
    check(indicator_out, ec, "indicator");
    rd(FAULT_WORD_ADDR, {12'h000, ef}, "fault read");
    rd(INDICATOR_ADDR, ec, "indicator read");
  endtask
  initial begin
    clk_in = 1'b0;
    rst_in = 1'b1;
    meas_in = BASE;
    link_in = 6'h00;
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    go(0, 16'h0046, 6'h00, 4'h0, CODE_HEALTHY);
    go(0, 16'h0046, 6'h20, 4'h1, CODE_YEL5);
    go(0, 16'h0046, 6'h01, 4'h0, CODE_ACQUIRING);
    go(0, 16'h00B1, 6'h00, 4'h8, CODE_YEL3);
    go(0, 16'h00B0, 6'h00, 4'h0, CODE_HEALTHY);
    go(0, 16'hFFFF, 6'h00, 4'h8, CODE_YEL3);
    go(1, 16'h0038, 6'h00, 4'h8, CODE_YEL4);
    go(1, 16'h0037, 6'h00, 4'h0, CODE_HEALTHY);
    go(1, 16'h002C, 6'h00, 4'h8, CODE_YEL4);
    go(4, 16'h0078, 6'h00, 4'h0, CODE_YEL2);
    go(4, 16'h0079, 6'h00, 4'h0, CODE_HEALTHY);
    go(3, 16'h0DAD, 6'h00, 4'h0, CODE_YEL1);
    go(3, 16'h0DAC, 6'h00, 4'h0, CODE_HEALTHY);
    go(3, 16'h1195, 6'h00, 4'h0, CODE_RED1);
    go(0, 16'h0046, 6'h04, 4'h0, CODE_RED1);
    go(2, 16'h0149, 6'h00, 4'h8, CODE_RED2);
    go(2, 16'h0149, 6'h02, 4'h8, CODE_HEALTHY);
    go(4, 16'h0071, 6'h00, 4'h8, CODE_RED5);
    go(4, 16'h00B0, 6'h00, 4'h8, CODE_RED5);
    go(4, 16'h00AF, 6'h00, 4'h0, CODE_HEALTHY);
    go(0, 16'h0046, 6'h10, 4'h2, CODE_RED4);
    go(0, 16'h0046, 6'h08, 4'h4, CODE_RED3);
    go(3, 16'h11F8, 6'h08, 4'h4, CODE_RED3);
    go(0, 16'h0046, 6'h0A, 4'h4, CODE_HEALTHY);
    go(1, 16'h0038, 6'h00, 4'h8, CODE_YEL4);
    go(1, 16'h0038, 6'h38, 4'hF, CODE_RED3);
    go(0, 16'h0046, 6'h00, 4'h0, CODE_HEALTHY);
    rd(8'h08, 16'h0000, "unmapped read");
    go(0, 16'h0046, 6'h20, 4'h1, CODE_YEL5);
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    check(fault_word_out, REG_RESET_VALUE, "fault in reset");
    check(indicator_out, REG_RESET_VALUE, "indicator in reset");
    complete_run();
  end
endmodule
